/* logic/trig_pwm_pkg.sv */
package trig_pwm_pkg;
   // register map, word addresses on the plain register port
   localparam logic [3:0] ADDR_CTRL0 = 4'h0;
   localparam logic [3:0] ADDR_CTRL1 = 4'h1;
   localparam logic [3:0] ADDR_EDGE = 4'h2;
   localparam logic [3:0] ADDR_PERIOD = 4'h3;
   localparam logic [3:0] ADDR_DUTY = 4'h4;
   localparam logic [3:0] ADDR_COUNT = 4'h5;
   localparam logic [3:0] ADDR_STATUS = 4'h6;
   // field positions
   localparam int CE_BIT = 7;
   localparam int EST_BIT = 6;
   localparam int MODE_LSB = 0;
   localparam int ETS_LSB = 0;
   localparam int EES_LSB = 2;
   localparam int OVF_BIT = 0;
   // mode codes and reset values
   localparam logic [2:0] MODE_EVENT = 3'h1;
   localparam logic [2:0] MODE_TRIG = 3'h2;
   localparam logic [15:0] CNT_IDLE = 16'hffff;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CMP_RESET = 16'h0000;
   localparam logic [7:0] EDGE_RESET = 8'h00;
   localparam logic [7:0] EDGE_MASK = 8'h0f;
   // edge select codes
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic period_match_irq;
      logic duty_match_irq;
   } irq_t;

   typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_RUN} run_state_t;
endpackage : trig_pwm_pkg

/* logic/trigger_pwm_event_counter.sv */
`timescale 1ns/100ps
`default_nettype none
module trigger_pwm_event_counter
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic count_tick,
   input wire logic event_in,
   input wire logic trigger_in,
   input wire trig_pwm_pkg::reg_req_t req,
   output logic [15:0] rdata,
   output trig_pwm_pkg::irq_t irq,
   output logic square_wave_out,
   output logic pwm_duty_out
);
   import trig_pwm_pkg::*;

   // decode one edge-select field against the previous and present level
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic prev, input logic cur);
      unique case (sel)
         EDGE_NONE: edge_hit = 1'b0;
         EDGE_RISE: edge_hit = !prev && cur;
         EDGE_FALL: edge_hit = prev && !cur;
         EDGE_BOTH: edge_hit = prev != cur;
      endcase
   endfunction : edge_hit

   logic count_enable_bit;
   logic [2:0] operating_mode_sel;
   logic [7:0] edge_select_control;
   logic [15:0] period_compare_reg, duty_compare_reg;
   logic [15:0] period_compare_buffer, duty_compare_buffer;
   logic [15:0] counter;
   logic overflow_flag;
   logic sw_trig_mode;
   logic reload_armed;
   logic event_prev, trigger_prev;
   run_state_t state;

   wire logic wr_ctrl0 = req.wr && req.addr == ADDR_CTRL0;
   wire logic wr_ctrl1 = req.wr && req.addr == ADDR_CTRL1;
   wire logic wr_period = req.wr && req.addr == ADDR_PERIOD;
   wire logic wr_duty = req.wr && req.addr == ADDR_DUTY;
   wire logic is_trig = operating_mode_sel == MODE_TRIG;
   wire logic is_event = operating_mode_sel == MODE_EVENT;

   // software trigger is a write of 1 to the trigger bit, not a stored level
   wire logic sw_trig = wr_ctrl1 && req.wdata[EST_BIT];
   wire logic hw_trig = edge_hit(edge_select_control[ETS_LSB +: 2],
                                 trigger_prev, trigger_in);
   wire logic any_trig = is_trig && count_enable_bit
                         && (sw_trig || hw_trig);
   wire logic ev_edge = edge_hit(edge_select_control[EES_LSB +: 2],
                                 event_prev, event_in);
   // the count step: event edges in event mode, count clock otherwise
   wire logic step = (state == ST_RUN)
                     && (is_event ? ev_edge : count_tick);
   wire logic period_hit = counter == period_compare_buffer;

   // input history for edge detection
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         event_prev <= 1'b0;
         trigger_prev <= 1'b0;
      end else begin
         event_prev <= event_in;
         trigger_prev <= trigger_in;
      end
   end

   // control registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_enable_bit <= 1'b0;
         operating_mode_sel <= MODE_EVENT;
         edge_select_control <= EDGE_RESET;
         period_compare_reg <= CMP_RESET;
         duty_compare_reg <= CMP_RESET;
      end else begin
         if (wr_ctrl0)
            count_enable_bit <= req.wdata[CE_BIT];
         if (wr_ctrl1)
            operating_mode_sel <= req.wdata[MODE_LSB +: 3];
         if (req.wr && req.addr == ADDR_EDGE)
            edge_select_control <= req.wdata[7:0] & EDGE_MASK;
         if (wr_period)
            period_compare_reg <= req.wdata;
         if (wr_duty)
            duty_compare_reg <= req.wdata;
      end
   end

   // run state: stopped, waiting for trigger, running
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_STOP;
      end else if (!count_enable_bit) begin
         state <= ST_STOP;
      end else begin
         unique case (state)
            ST_STOP: state <= is_trig ? ST_WAIT : ST_RUN;
            ST_WAIT: if (any_trig) state <= ST_RUN;
            ST_RUN: state <= ST_RUN;
         endcase
      end
   end

   // counter; trigger restarts from zero, match clears, FFFFH wraps (silently only in event mode, else overflow_flag sets)
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         counter <= CNT_IDLE;
      end else if (state != ST_RUN) begin
         counter <= (state == ST_STOP && count_enable_bit && !is_trig)
                    ? CNT_ZERO : CNT_IDLE;
         if (state == ST_WAIT && any_trig)
            counter <= CNT_ZERO;
      end else if (any_trig) begin
         counter <= CNT_ZERO;
      end else if (step) begin
         counter <= period_hit ? CNT_ZERO
                    : 16'(counter + 16'h0001);
      end
   end

   // overflow flag never set by a period match; set beats a same-cycle clear
   always_ff @(posedge clk) begin
      if (!rst_n)
         overflow_flag <= 1'b0;
      else if (step && counter == CNT_IDLE && !period_hit && !is_event)
         overflow_flag <= 1'b1;
      else if (wr_ctrl0 && !req.wdata[CE_BIT])
         overflow_flag <= 1'b0;
   end

   // compare buffers; event mode follows writes at once, trigger mode
   // reloads at the period clear once a duty write has armed it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         period_compare_buffer <= CMP_RESET;
         duty_compare_buffer <= CMP_RESET;
         reload_armed <= 1'b0;
      end else if (state != ST_RUN) begin
         period_compare_buffer <= period_compare_reg;
         duty_compare_buffer <= duty_compare_reg;
         reload_armed <= 1'b0;
      end else if (!is_trig) begin
         if (wr_period)
            period_compare_buffer <= req.wdata;
         if (wr_duty)
            duty_compare_buffer <= req.wdata;
      end else begin
         if (wr_duty)
            reload_armed <= 1'b1;
         if (step && period_hit && reload_armed && !any_trig) begin
            period_compare_buffer <= period_compare_reg;
            duty_compare_buffer <= duty_compare_reg;
            reload_armed <= wr_duty;
         end
      end
   end

   // interrupts as one-cycle pulses
   wire logic duty_eq = counter == duty_compare_buffer;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq <= '0;
      end else begin
         irq.period_match_irq <= step && period_hit
                                 && !any_trig;
         // trigger mode: flags at the count that reaches the duty value
         if (is_trig)
            irq.duty_match_irq <= step && !any_trig && !period_hit
                && 16'(counter + 16'h0001) == duty_compare_buffer;
         else
            irq.duty_match_irq <= step && duty_eq && !period_hit
                && duty_compare_buffer <= period_compare_buffer;
      end
   end

   // pwm output, trigger mode only (held low in other modes): high from clear until duty count, low while waiting
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwm_duty_out <= 1'b0;
      end else if (!is_trig || state != ST_RUN) begin
         pwm_duty_out <= (state == ST_WAIT && any_trig)
                         && duty_compare_buffer != CNT_ZERO;
      end else if (any_trig) begin
         pwm_duty_out <= 1'b1;
      end else if (step) begin
         if (period_hit)
            pwm_duty_out <= duty_compare_buffer != CNT_ZERO;
         else if (16'(counter + 16'h0001) == duty_compare_buffer)
            pwm_duty_out <= 1'b0;
      end
   end

   // square output toggles at each software-started pwm cycle start
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         square_wave_out <= 1'b0;
         sw_trig_mode <= 1'b0;
      end else begin
         if (any_trig)
            sw_trig_mode <= sw_trig;
         if (!is_trig || state == ST_STOP)
            square_wave_out <= 1'b0;
         else if (any_trig && sw_trig)
            square_wave_out <= !square_wave_out;
         else if (sw_trig_mode && state == ST_RUN && step && period_hit)
            square_wave_out <= !square_wave_out;
      end
   end

   // read port, data one cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (req.rd) begin
         unique case (req.addr)
            ADDR_CTRL0: rdata <= 16'(count_enable_bit) << CE_BIT;
            ADDR_CTRL1: rdata <= {13'h0000, operating_mode_sel};
            ADDR_EDGE: rdata <= {8'h00, edge_select_control};
            ADDR_PERIOD: rdata <= period_compare_reg;
            ADDR_DUTY: rdata <= duty_compare_reg;
            ADDR_COUNT: rdata <= counter;
            ADDR_STATUS: rdata <= {15'h0000, overflow_flag};
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // checks on counting, compare matches, buffers and the read port
   chk_wrap_no_ovf: assert property (@(posedge clk)
      disable iff (!rst_n)
      is_event && step && counter == CNT_IDLE && period_hit
      |=> counter == CNT_ZERO && irq.period_match_irq && !overflow_flag)
      else $error("wrap at full scale misbehaved");
   chk_event_count: assert property (@(posedge clk)
      disable iff (!rst_n)
      is_event && step && !period_hit
      |=> counter == $past(counter) + 16'h0001)
      else $error("event edge did not advance counter");
   chk_period_live: assert property (@(posedge clk)
      disable iff (!rst_n)
      is_event && state == ST_RUN && wr_period
      |=> period_compare_buffer == $past(req.wdata))
      else $error("period write did not reach buffer");
   chk_duty_never: assert property (@(posedge clk)
      disable iff (!rst_n)
      is_event && duty_compare_buffer > period_compare_buffer
      && $stable(duty_compare_buffer) |=> !irq.duty_match_irq)
      else $error("duty irq above period");
   chk_trig_restart: assert property (@(posedge clk)
      disable iff (!rst_n)
      any_trig && state == ST_RUN
      |=> counter == CNT_ZERO && pwm_duty_out)
      else $error("trigger did not restart");
   chk_wait_idle: assert property (@(posedge clk)
      disable iff (!rst_n)
      state == ST_WAIT && $past(state) == ST_WAIT
      |-> counter == CNT_IDLE && !pwm_duty_out)
      else $error("waiting state not idle");
   chk_first_trig: assert property (@(posedge clk)
      disable iff (!rst_n)
      state == ST_WAIT && any_trig |=> state == ST_RUN
      && counter == CNT_ZERO)
      else $error("first trigger did not start");
   chk_period_irq: assert property (@(posedge clk)
      disable iff (!rst_n)
      is_trig && state == ST_RUN && step && period_hit && !any_trig
      |=> irq.period_match_irq && counter == CNT_ZERO)
      else $error("period irq not at clear");
   chk_trig_duty: assert property (@(posedge clk)
      disable iff (!rst_n)
      $past(is_trig) && irq.duty_match_irq
      |-> counter == duty_compare_buffer && !pwm_duty_out)
      else $error("duty irq not at duty match");
   chk_buffer_hold: assert property (@(posedge clk)
      disable iff (!rst_n)
      is_trig && state == ST_RUN && !(step && period_hit)
      |=> $stable(period_compare_buffer) && $stable(duty_compare_buffer))
      else $error("compare buffer reloaded off the clear");
   chk_count_read: assert property (@(posedge clk)
      disable iff (!rst_n)
      req.rd && req.addr == ADDR_COUNT |=> rdata == $past(counter))
      else $error("count read wrong");
   chk_edge_upper: assert property (@(posedge clk)
      disable iff (!rst_n)
      req.rd && req.addr == ADDR_EDGE |=> rdata[15:4] == 12'h000)
      else $error("edge select upper bits set");
endmodule : trigger_pwm_event_counter
`default_nettype wire

/* testbench/trig_pwm_partner.sv */
`timescale 1ns/100ps
`default_nettype none
// far side pins: event source and trigger source
module trig_pwm_partner (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ev_go,
   input wire logic tr_go,
   output logic event_in,
   output logic trigger_in
);
   // event line flips every clock while asked, one edge per clock
   always_ff @(posedge clk) begin
      if (!rst_n) event_in <= 1'b0;
      else if (ev_go) event_in <= ~event_in;
   end
   // trigger level follows the request, so its rise is the edge
   always_ff @(posedge clk) begin
      if (!rst_n) trigger_in <= 1'b0;
      else trigger_in <= tr_go;
   end
endmodule : trig_pwm_partner
`default_nettype wire

/* testbench/trigger_pwm_event_counter_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module trigger_pwm_event_counter_tb;
   import trig_pwm_pkg::*;
   logic clk, rst_n, count_tick, ev_go, tr_go, event_in, trigger_in;
   logic square_wave_out, pwm_duty_out;
   reg_req_t req;
   irq_t irq;
   logic [15:0] rdata, v, p, d;
   logic [31:0] seed;
   int mismatches, cmp_count, n_pm, n_dm, pm0, dm0, n;
   trigger_pwm_event_counter i_dut (.clk(clk), .rst_n(rst_n),
      .count_tick(count_tick), .event_in(event_in),
      .trigger_in(trigger_in), .req(req), .rdata(rdata), .irq(irq),
      .square_wave_out(square_wave_out), .pwm_duty_out(pwm_duty_out));
   trig_pwm_partner i_far (.clk(clk), .rst_n(rst_n), .ev_go(ev_go),
      .tr_go(tr_go), .event_in(event_in), .trigger_in(trigger_in));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // irq tallies; scenarios read them against a baseline, never reset them
   always @(posedge clk) begin
      if (irq.period_match_irq === 1'b1) n_pm <= n_pm + 1;
      if (irq.duty_match_irq === 1'b1) n_dm <= n_dm + 1;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   // expected pwm low time: period plus one minus active width
   function automatic logic [15:0] low_len(input logic [15:0] pp,
         input logic [15:0] dd);
      return pp + 16'd1 - dd;
   endfunction : low_len
   function automatic logic sig(input bit sq);
      return sq ? square_wave_out : pwm_duty_out;
   endfunction : sig
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [15:0] w);
      @(posedge clk);
      req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rchk(input string what, input logic [3:0] a,
         input logic [15:0] exp);
      @(posedge clk);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 v = rdata;
      chk(what, exp, v);
   endtask : rchk
   task automatic pulses(input int k);
      @(posedge clk);
      ev_go <= 1'b1;
      repeat (k) @(posedge clk);
      ev_go <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : pulses
   // length of the next full run of the chosen output at lvl
   task automatic span(input bit sq, input logic lvl, output int len);
      int i;
      tick(); // start on a settled sample, never at the launching edge
      for (i = 0; i < 300 && sig(sq) === lvl; i++) tick();
      for (i = 0; i < 300 && sig(sq) !== lvl; i++) tick();
      for (len = 0; len < 300 && sig(sq) === lvl; len++) tick();
   endtask : span
   initial begin
      rst_n = 1'b0;
      count_tick = 1'b0;
      ev_go = 1'b0;
      tr_go = 1'b0;
      req = '0;
      seed = 32'hee7c;
      fork
      begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      // reset state, edge register masking, unmapped read
      rchk("count idle", ADDR_COUNT, CNT_IDLE);
      wr(ADDR_EDGE, 16'h00ff);
      rchk("edge reg", ADDR_EDGE, {8'h00, EDGE_MASK});
      rchk("unmapped", 4'hf, 16'h0000);
      // event counting on rising edges, period 4, duty 2
      wr(ADDR_EDGE, {12'h0, EDGE_RISE, 2'b00});
      wr(ADDR_CTRL1, {13'h0, MODE_EVENT});
      wr(ADDR_PERIOD, 16'h0004);
      wr(ADDR_DUTY, 16'h0002);
      wr(ADDR_CTRL0, 16'h0080);
      pm0 = n_pm;
      dm0 = n_dm;
      pulses(30);
      chk("period irqs", 16'd3, 16'(n_pm - pm0));
      chk("duty irqs", 16'd3, 16'(n_dm - dm0));
      pulses(4);
      rchk("live count", ADDR_COUNT, 16'h0002);
      wr(ADDR_DUTY, 16'h0006);
      dm0 = n_dm;
      pulses(20);
      chk("no duty irq", 16'd0, 16'(n_dm - dm0));
      // raise the limit while counting: the new value applies at once
      wr(ADDR_PERIOD, 16'h0008);
      pulses(16);
      rchk("new limit", ADDR_COUNT, 16'h0001);
      // full-scale limit on both edges; halt before changing the limit
      wr(ADDR_CTRL0, 16'h0000);
      wr(ADDR_EDGE, {12'h0, EDGE_BOTH, 2'b00});
      wr(ADDR_PERIOD, 16'hffff);
      wr(ADDR_CTRL0, 16'h0080);
      pm0 = n_pm;
      pulses(65535);
      rchk("full count", ADDR_COUNT, 16'hffff);
      chk("no early irq", 16'd0, 16'(n_pm - pm0));
      pulses(1);
      rchk("wrap", ADDR_COUNT, CNT_ZERO);
      chk("wrap irq", 16'd1, 16'(n_pm - pm0));
      rchk("no overflow", ADDR_STATUS, 16'h0000);
      // trigger pulse mode, random widths, second pass rewrites live
      wr(ADDR_CTRL0, 16'h0000);
      wr(ADDR_CTRL1, {13'h0, MODE_TRIG});
      wr(ADDR_EDGE, {14'h0, EDGE_RISE});
      count_tick <= 1'b1;
      for (int it = 0; it < 2; it++) begin
         seed = xs(seed);
         d = 16'd4 + {13'h0, seed[2:0]};
         p = d + 16'd12 + {12'h0, seed[7:4]};
         if (it == 1) span(0, 1'b0, n);
         wr(ADDR_PERIOD, p);
         wr(ADDR_DUTY, d);
         if (it == 0) begin
            wr(ADDR_CTRL0, 16'h0080);
            repeat (5) @(posedge clk);
            rchk("await trigger", ADDR_COUNT, CNT_IDLE);
            chk("pwm idle", 16'h0, {15'h0, pwm_duty_out});
            @(posedge clk);
            tr_go <= 1'b1;
            repeat (2) @(posedge clk);
            tr_go <= 1'b0;
         end
         span(0, 1'b1, n);
         chk("pwm high", d, n[15:0]);
         chk("duty irq at fall", 16'h1, {15'h0, irq.duty_match_irq});
         span(0, 1'b0, n);
         chk("pwm low", low_len(p, d), n[15:0]);
         chk("irq at clear", 16'h1, {15'h0, irq.period_match_irq});
      end
      // software trigger early in the low phase
      span(0, 1'b1, n);
      v[0] = square_wave_out;
      wr(ADDR_CTRL1, {9'h0, 1'b1, 3'h0, MODE_TRIG});
      tick();
      tick();
      chk("pwm forced high", 16'h1, {15'h0, pwm_duty_out});
      chk("square flip", {15'h0, ~v[0]}, {15'h0, square_wave_out});
      span(1, square_wave_out, n);
      chk("square half period", p + 16'd1, n[15:0]);
      end
      // hang guard; the full-scale wrap dominates the run time
      begin
         repeat (90000) @(posedge clk);
         mismatches++;
         $display("mismatch timeout expected done seen hang");
      end
      join_any
      disable fork;
      summarize();
   end
endmodule : trigger_pwm_event_counter_tb
`default_nettype wire
